/* verification/crecf_host_model.sv */
// Host side: raises resets and waits out the start-up hold
module crecf_host_model
(
    input  wire logic clock_i,
    input  wire logic in_reset_i,    // Device start-up hold
    input  wire logic kind_i,        // 0 pin, 1 command
    input  wire logic go_i,          // Reset request level
    output logic      reset_pin_n_o, // Reset pin, low active
    output logic      spi_reset_o,   // Reset command
    output logic      ready_o        // Host may start transfers
);
    timeunit 1ns;
    timeprecision 1ps;
    assign reset_pin_n_o = !(go_i && !kind_i);
    assign spi_reset_o   = go_i && kind_i;
    // wait for hold, seen one clock late
    always_ff @(posedge clock_i)
    begin
        ready_o <= !in_reset_i && !go_i;
    end
endmodule

/* verification/tb_clock_reset_error_flags.sv */
`include "crecf_defines.svh"

// Self-checking bench for the clock, reset and error flag block
module tb_clock_reset_error_flags;
    timeunit 1ns;
    timeprecision 1ps;
    import crecf_pkg::*;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic wake_i = 1'b0;
    logic sleep_req_i = 1'b0;
    logic clock_output_enable_i = 1'b1;
    crecf_presel_type presel_i = 2'h3;
    crecf_count_type tx = 9'h000;
    crecf_count_type rx = 9'h000;
    logic err_clear_i = 1'b0;
    logic err_ie_i = 1'b0;
    logic kind = 1'b0;
    logic go = 1'b0;
    logic pin_n, spi_rst, ready, in_reset_o, asleep_o, clk_o, oe_n, err_flag_o, int_n_o;
    logic [`CRECF_EF_WIDTH-1:0] error_flags_o;
    int err_total = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seed = 32'h0456;
    int hi, lo, n, rises;
    logic prev;
    int exp_hi[4] = '{20, 1, 2, 4};
    int exp_lo[4] = '{0, 1, 2, 4};
    crecf_count_type ctx[8] = '{9'h05f, 9'h060, 9'h07f, 9'h080, 9'h0ff, 9'h100, 9'h000, 9'h1ff};

    crecf_top crecf_top_i (.clock_i(clock_i), .rst_i(rst_i), .reset_pin_n_i(pin_n),
        .spi_reset_i(spi_rst), .wake_i(wake_i), .sleep_req_i(sleep_req_i),
        .clock_output_enable_i(clock_output_enable_i), .presel_i(presel_i),
        .transmit_error_count_i(tx), .receive_error_count_i(rx), .err_clear_i(err_clear_i),
        .err_ie_i(err_ie_i), .in_reset_o(in_reset_o), .asleep_o(asleep_o),
        .prescaled_clock_output_o(clk_o), .prescaled_clock_output_oe_n_o(oe_n),
        .error_flags_o(error_flags_o), .err_flag_o(err_flag_o), .int_n_o(int_n_o));
    crecf_host_model crecf_host_model_i (.clock_i(clock_i), .in_reset_i(in_reset_o),
        .kind_i(kind), .go_i(go), .reset_pin_n_o(pin_n), .spi_reset_o(spi_rst),
        .ready_o(ready));

    // Clock, 5 ns period
    initial
    begin
        forever #2.5 clock_i = ~clock_i;
    end

    // Hang guard
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            print_verdict();
        end
    end

    // Expected error indications
    function automatic logic [5:0] expf(input crecf_count_type t, input crecf_count_type r);
        return {t > 9'h0ff, t > 9'h07f, r > 9'h07f, t >= 9'h060, r >= 9'h060,
                (t >= 9'h060) || (r >= 9'h060)};
    endfunction

    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_rng(input string nm, input int lo_v, input int hi_v, input int g);
        cmp_count++;
        if (g < lo_v || g > hi_v)
        begin
            err_total++;
            $display("mismatch %s expected %0d..%0d seen %0d", nm, lo_v, hi_v, g);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clock_i);
    endtask

    // Cycles until the start-up hold ends
    task automatic hold_len(output int k);
        k = 0;
        while (in_reset_o === 1'b1 && k < 400)
        begin
            cyc(1);
            k++;
        end
    endtask

    // One high and one low phase of the output, in clocks
    task automatic phase(output int h, output int l);
        int g;
        g = 0;
        h = 0;
        l = 0;
        while (clk_o !== 1'b0 && g < 20)
        begin
            cyc(1);
            g++;
        end
        while (clk_o !== 1'b1 && g < 40)
        begin
            cyc(1);
            g++;
        end
        while (clk_o === 1'b1 && h < 20)
        begin
            cyc(1);
            h++;
        end
        while (clk_o === 1'b0 && l < 20 && h < 20)
        begin
            cyc(1);
            l++;
        end
    endtask

    task automatic print_verdict();
        $display("counts: %0d compares, %0d mismatches", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        cyc(10);
        rst_i = 1'b0;
        hold_len(n);
        chk_rng("por hold", 127, 130, n);
        cyc(1);
        chk("ready", 1'b1, ready);
        $display("test power-on done");
        for (int c = 3; c >= 0; c--)
        begin
            presel_i = 2'(c);
            phase(hi, lo);
            phase(hi, lo);
            chk("high len", 9'(exp_hi[c]), 9'(hi));
            chk("low len", 9'(exp_lo[c]), 9'(lo));
        end
        $display("test prescaler done");
        clock_output_enable_i = 1'b0;
        cyc(20);
        chk("oe_n off", 1'b1, oe_n);
        for (int k = 0; k < 2; k++)
        begin
            kind = 1'(k);
            go = 1'b1;
            cyc(2);
            go = 1'b0;
            phase(hi, lo);
            chk("hold high", 9'h004, 9'(hi));
            chk("hold low", 9'h004, 9'(lo));
            chk("hold oe_n", 1'b0, oe_n);
            chk("wait host", 1'b0, ready);
            hold_len(n);
            chk_rng("reset hold", 90, 130, n);
        end
        clock_output_enable_i = 1'b1;
        presel_i = 2'h3;
        cyc(20);
        chk("oe_n on", 1'b0, oe_n);
        $display("test resets done");
        sleep_req_i = 1'b1;
        n = 0;
        rises = 0;
        while (asleep_o !== 1'b1 && n < 400)
        begin
            prev = clk_o;
            cyc(1);
            n++;
            if (clk_o === 1'b1 && prev === 1'b0)
            begin
                rises++;
            end
        end
        chk_rng("drain", 129, 136, n);
        chk_rng("drain pulses", 16, 17, rises);
        chk("asleep", 1'b1, asleep_o);
        cyc(3);
        chk("sleep out", 1'b0, clk_o);
        cyc(9);
        chk("sleep out", 1'b0, clk_o);
        chk("sleep oe_n", 1'b0, oe_n);
        sleep_req_i = 1'b0;
        wake_i = 1'b1;
        cyc(1);
        wake_i = 1'b0;
        cyc(1);
        hold_len(n);
        chk_rng("wake hold", 126, 130, n);
        chk("awake", 1'b0, asleep_o);
        $display("test sleep done");
        for (int i = 0; i < 40; i++)
        begin
            tx = (i < 8) ? ctx[i] : 9'($random(seed));
            rx = (i < 8) ? ctx[7 - i] : 9'($random(seed));
            cyc(2);
            chk("flags", 9'(expf(tx, rx)), 9'(error_flags_o));
        end
        $display("test flags done");
        err_ie_i = 1'b1;
        tx = 9'h000;
        rx = 9'h000;
        cyc(3);
        err_clear_i = 1'b1;
        cyc(1);
        err_clear_i = 1'b0;
        cyc(3);
        chk("err clear", 1'b0, err_flag_o);
        chk("int idle", 1'b1, int_n_o);
        tx = 9'h060;
        cyc(3);
        chk("err set", 1'b1, err_flag_o);
        chk("int low", 1'b0, int_n_o);
        err_clear_i = 1'b1;
        cyc(1);
        err_clear_i = 1'b0;
        cyc(3);
        chk("clear refused", 1'b1, err_flag_o);
        err_ie_i = 1'b0;
        tx = 9'h000;
        cyc(3);
        chk("int masked", 1'b1, int_n_o);
        chk("err kept", 1'b1, err_flag_o);
        err_clear_i = 1'b1;
        cyc(1);
        err_clear_i = 1'b0;
        cyc(3);
        chk("err cleared", 1'b0, err_flag_o);
        $display("test interrupt done");
        print_verdict();
    end
endmodule

/* verilog/crecf_defines.svh */
`ifndef CRECF_DEFINES_SVH
`define CRECF_DEFINES_SVH

// Error counter limits
`define CRECF_WARN_LIMIT      9'h060
`define CRECF_PASSIVE_LIMIT   9'h07f
`define CRECF_BUSOFF_LIMIT    9'h0ff
// Start-up timer length in oscillator cycles
`define CRECF_OST_CYCLES      8'h80
`define CRECF_OST_LAST        8'h7f
// Extra output cycles before sleep
`define CRECF_SLEEP_CYCLES    5'h10
// Prescaler select codes
`define CRECF_PRE_DIV1        2'h0
`define CRECF_PRE_DIV2        2'h1
`define CRECF_PRE_DIV4        2'h2
`define CRECF_PRE_DIV8        2'h3
`define CRECF_PRE_RESET       2'h3
// Error flag bit positions
`define CRECF_EF_WARN         0
`define CRECF_EF_RXWARN       1
`define CRECF_EF_TXWARN       2
`define CRECF_EF_RXPASS       3
`define CRECF_EF_TXPASS       4
`define CRECF_EF_BUSOFF       5
`define CRECF_EF_WIDTH        6

`endif

/* verilog/crecf_pkg.sv */
package crecf_pkg;
    // Counters are nine bits so a count above 255 can be seen
    typedef logic [8:0] crecf_count_type;
    // Prescaler select field
    typedef logic [1:0] crecf_presel_type;
    // Clock output sequencing states
    typedef enum logic [1:0]
    {
        CRECF_CK_RUN   = 2'b00,
        CRECF_CK_DRAIN = 2'b01,
        CRECF_CK_SLEEP = 2'b10
    } crecf_ckstate_type;
endpackage

/* verilog/crecf_prescaler.sv */
`include "crecf_defines.svh"

// Prescaled clock generator; settings applied only at period boundaries
module crecf_prescaler
(
    input  wire logic                        clock_i,
    input  wire logic                        rst_i,
    input  wire crecf_pkg::crecf_presel_type presel_i,   // Requested divide select
    output logic                             level_o,    // Divided clock level
    output logic                             boundary_o  // Last cycle of a period
);
    import crecf_pkg::*;

    logic [2:0]        phase_r;   // Position within period
    crecf_presel_type  sel_r;     // Active divide select

    // Period length minus one for a select code
    function automatic logic [2:0] last_phase(input crecf_presel_type s);
        unique case (s)
            `CRECF_PRE_DIV1: last_phase = 3'h0;
            `CRECF_PRE_DIV2: last_phase = 3'h1;
            `CRECF_PRE_DIV4: last_phase = 3'h3;
            `CRECF_PRE_DIV8: last_phase = 3'h7;
        endcase
    endfunction

    assign boundary_o = (phase_r == last_phase(sel_r));

    // Phase counter and select latch
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            phase_r <= 3'h0;
            sel_r   <= `CRECF_PRE_RESET;
        end
        else if (boundary_o)
        begin
            phase_r <= 3'h0;
            sel_r   <= presel_i;
        end
        else
        begin
            phase_r <= phase_r + 3'h1;
        end
    end

    // Divide by one passes nothing finer than the clock; show high then
    always_comb
    begin
        if (sel_r == `CRECF_PRE_DIV1)
            level_o = 1'b1;
        else
            level_o = (phase_r <= (last_phase(sel_r) >> 1));
    end
endmodule

/* verilog/crecf_top.sv */
// What this block does
// - Transmit count reaching 96 raises warning
// - Receive count above 127 flags passive
// - Transmit count above 127 flags passive
// - Transmit count above 255 means bus-off
// - Interrupt pending while error interrupt flag set and interrupt enabled
// - Clearing flag ignored while cause persists
// - Hold reset 128 cycles after reset events
// - Output clock divides by 1, 2, 4, 8
// - After reset output enabled, divide eight
// - Sixteen output cycles before entering sleep
// - Asleep and enabled, output rests low
// - Enable zero makes output high impedance
// - Changes only at output period boundaries; sleep exit and reset hold apply on the next clock
// - Reset from pin low or command
// - Both reset sources act identically
`include "crecf_defines.svh"

module crecf_top
(
    input  wire logic                         clock_i,           // Oscillator input clock
    input  wire logic                         rst_i,             // Power-on reset
    input  wire logic                         reset_pin_n_i,     // Reset pin, low active
    input  wire logic                         spi_reset_i,       // Reset command pulse
    input  wire logic                         wake_i,            // Wake-up from sleep pulse
    input  wire logic                         sleep_req_i,       // Sleep request level
    input  wire logic                         clock_output_enable_i,
    input  wire crecf_pkg::crecf_presel_type  presel_i,          // Prescaler select
    input  wire crecf_pkg::crecf_count_type   transmit_error_count_i,
    input  wire crecf_pkg::crecf_count_type   receive_error_count_i,
    input  wire logic                         err_clear_i,       // Host clears error flag
    input  wire logic                         err_ie_i,          // Error interrupt enable
    output logic                              in_reset_o,        // Start-up timer active
    output logic                              asleep_o,          // Sleep entered
    output logic                              prescaled_clock_output_o,
    output logic                              prescaled_clock_output_oe_n_o,
    output logic [`CRECF_EF_WIDTH-1:0]        error_flags_o,
    output logic                              err_flag_o,        // Error interrupt flag
    output logic                              int_n_o            // Interrupt, low active
);
    import crecf_pkg::*;

    logic [7:0]                 ost_r;        // Start-up timer count
    logic                       hold_r;       // Internal reset hold
    crecf_ckstate_type          ck_r;         // Output sequencing state
    logic [4:0]                 drain_r;      // Cycles left before sleep
    logic                       asleep_r;     // Sleep entered, registered
    logic                       en_r;         // Applied output enable
    logic                       out_r;        // Output pin level
    logic                       oe_n_r;       // Output pin enable, low drives
    logic [`CRECF_EF_WIDTH-1:0] ef_r;         // Error indications
    logic [`CRECF_EF_WIDTH-1:0] ef_nxt;
    logic                       errf_r;       // Error interrupt flag
    logic                       int_n_r;
    logic                       div_level;
    logic                       div_bound;
    logic                       reset_evt;
    crecf_presel_type           sel_eff;

    assign reset_evt = !reset_pin_n_i || spi_reset_i || wake_i;

    assign sel_eff = hold_r ? `CRECF_PRE_RESET : presel_i;

    crecf_prescaler u_div
    (
        .clock_i    (clock_i),
        .rst_i      (rst_i),
        .presel_i   (sel_eff),
        .level_o    (div_level),
        .boundary_o (div_bound)
    );

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ost_r  <= 8'h00;
            hold_r <= 1'b1;
        end
        else if (reset_evt)
        begin
            ost_r  <= 8'h00;
            hold_r <= 1'b1;
        end
        else if (hold_r)
        begin
            ost_r  <= ost_r + 8'h01;
            hold_r <= (ost_r != `CRECF_OST_LAST);
        end
    end

    // Sleep sequencing; asleep flag kept beside the state
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ck_r     <= CRECF_CK_RUN;
            drain_r  <= 5'h00;
            asleep_r <= 1'b0;
        end
        else if (reset_evt || hold_r)
        begin
            ck_r     <= CRECF_CK_RUN;
            drain_r  <= 5'h00;
            asleep_r <= 1'b0;
        end
        else
        begin
            unique case (ck_r)
                CRECF_CK_RUN:
                    if (sleep_req_i && div_bound)
                    begin
                        ck_r    <= CRECF_CK_DRAIN;
                        drain_r <= `CRECF_SLEEP_CYCLES;
                    end
                CRECF_CK_DRAIN:
                    if (div_bound)
                    begin
                        if (drain_r == 5'h01)
                        begin
                            ck_r     <= CRECF_CK_SLEEP;
                            asleep_r <= 1'b1;
                        end
                        drain_r <= drain_r - 5'h01;
                    end
                // Leave sleep when request drops
                CRECF_CK_SLEEP:
                    if (!sleep_req_i)
                    begin
                        ck_r     <= CRECF_CK_RUN;
                        asleep_r <= 1'b0;
                    end
                // Unused code falls back to running
                default:
                begin
                    ck_r     <= CRECF_CK_RUN;
                    asleep_r <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            en_r <= 1'b1;
        else if (hold_r)
            en_r <= 1'b1;
        else if (div_bound)
            en_r <= clock_output_enable_i;
    end

    // Output pin drive
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            out_r  <= 1'b0;
            oe_n_r <= 1'b0;
        end
        else if (!en_r)
        begin
            out_r  <= 1'b0;
            oe_n_r <= 1'b1;
        end
        else if (ck_r == CRECF_CK_SLEEP)
        begin
            out_r  <= 1'b0;
            oe_n_r <= 1'b0;
        end
        else
        begin
            out_r  <= div_level;
            oe_n_r <= 1'b0;
        end
    end

    // Error indications from counters
    always_comb
    begin
        ef_nxt = '0;
        ef_nxt[`CRECF_EF_TXWARN] = transmit_error_count_i >= `CRECF_WARN_LIMIT;
        ef_nxt[`CRECF_EF_RXWARN] = receive_error_count_i >= `CRECF_WARN_LIMIT;
        ef_nxt[`CRECF_EF_WARN]   = ef_nxt[`CRECF_EF_TXWARN] || ef_nxt[`CRECF_EF_RXWARN];
        ef_nxt[`CRECF_EF_RXPASS] = receive_error_count_i > `CRECF_PASSIVE_LIMIT;
        ef_nxt[`CRECF_EF_TXPASS] = transmit_error_count_i > `CRECF_PASSIVE_LIMIT;
        ef_nxt[`CRECF_EF_BUSOFF] = transmit_error_count_i > `CRECF_BUSOFF_LIMIT;
    end

    // Registered indications
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            ef_r <= '0;
        else if (hold_r)
            ef_r <= '0;
        else
            ef_r <= ef_nxt;
    end

    // Error interrupt flag
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            errf_r <= 1'b0;
        else if (hold_r)
            errf_r <= 1'b0;
        else if (ef_nxt != ef_r)
            errf_r <= 1'b1;
        else if (err_clear_i && (ef_r == '0))
            errf_r <= 1'b0;
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            int_n_r <= 1'b1;
        else
            int_n_r <= !(errf_r && err_ie_i);
    end

    assign in_reset_o                    = hold_r;
    assign asleep_o                      = asleep_r;
    assign prescaled_clock_output_o      = out_r;
    assign prescaled_clock_output_oe_n_o = oe_n_r;
    assign error_flags_o                 = ef_r;
    assign err_flag_o                    = errf_r;
    assign int_n_o                       = int_n_r;

    a_ost_hold_len: assert property (@(posedge clock_i) disable iff (rst_i)
        $fell(reset_evt) |-> hold_r [*8]) else $error("start-up hold too short");

    a_hold_full: assert property (@(posedge clock_i) disable iff (rst_i)
        hold_r && (ost_r != `CRECF_OST_LAST) |=> hold_r) else $error("start-up hold ended early");

    a_hold_end: assert property (@(posedge clock_i) disable iff (rst_i)
        hold_r && !reset_evt && (ost_r == `CRECF_OST_LAST) |=> !hold_r)
        else $error("start-up hold overran");

    a_enable_reset: assert property (@(posedge clock_i) disable iff (rst_i)
        hold_r |=> en_r) else $error("output not enabled after reset");

    a_oe_when_off: assert property (@(posedge clock_i) disable iff (rst_i)
        !en_r |=> oe_n_r) else $error("output driven while disabled");

    a_sleep_low: assert property (@(posedge clock_i) disable iff (rst_i)
        (ck_r == CRECF_CK_SLEEP) && en_r |=> !out_r) else $error("output not low asleep");

    // Sleep request taken at a period end
    sequence s_sleep_taken;
        (ck_r == CRECF_CK_RUN) && sleep_req_i && div_bound && !reset_evt && !hold_r;
    endsequence

    // Last drain period ends
    sequence s_drain_done;
        (ck_r == CRECF_CK_DRAIN) && div_bound && (drain_r == 5'h01) && !reset_evt && !hold_r;
    endsequence

    a_drain_start: assert property (@(posedge clock_i) disable iff (rst_i)
        s_sleep_taken |=> (ck_r == CRECF_CK_DRAIN) && (drain_r == `CRECF_SLEEP_CYCLES))
        else $error("drain not started");

    a_sleep_entry: assert property (@(posedge clock_i) disable iff (rst_i)
        s_drain_done |=> asleep_o) else $error("sleep not entered");

    a_busoff_set: assert property (@(posedge clock_i) disable iff (rst_i)
        !hold_r && (transmit_error_count_i > `CRECF_BUSOFF_LIMIT)
        |=> ef_r[`CRECF_EF_BUSOFF]) else $error("bus-off missed");

    a_txwarn_set: assert property (@(posedge clock_i) disable iff (rst_i)
        !hold_r && (transmit_error_count_i >= `CRECF_WARN_LIMIT)
        |=> ef_r[`CRECF_EF_TXWARN]) else $error("transmit warning missed");

    a_rxpass_set: assert property (@(posedge clock_i) disable iff (rst_i)
        !hold_r && (receive_error_count_i > `CRECF_PASSIVE_LIMIT)
        |=> ef_r[`CRECF_EF_RXPASS]) else $error("receive passive missed");

    a_txpass_set: assert property (@(posedge clock_i) disable iff (rst_i)
        !hold_r && (transmit_error_count_i > `CRECF_PASSIVE_LIMIT)
        |=> ef_r[`CRECF_EF_TXPASS]) else $error("transmit passive missed");

    a_err_set: assert property (@(posedge clock_i) disable iff (rst_i)
        !hold_r && (ef_nxt != ef_r) |=> errf_r) else $error("error flag not set");

    a_clear_blocked: assert property (@(posedge clock_i) disable iff (rst_i)
        errf_r && (ef_r != '0) && !hold_r |=> errf_r) else $error("flag cleared early");

    a_int_pending: assert property (@(posedge clock_i) disable iff (rst_i)
        errf_r && err_ie_i |=> !int_n_o) else $error("interrupt not pending");

    a_int_idle: assert property (@(posedge clock_i) disable iff (rst_i)
        !errf_r |=> int_n_o) else $error("interrupt without flag");
endmodule
